/* File: design/tqos_pkg.sv */
// constants and types for the trigger qualify and occurrence setup block
package tqos_pkg;
  typedef enum logic [2:0] {
    TQOS_MODE_EDGE    = 3'h0,
    TQOS_MODE_PATTERN = 3'h1,
    TQOS_MODE_STATE   = 3'h2,
    TQOS_MODE_DELAY   = 3'h3,
    TQOS_MODE_TV      = 3'h4
  } tqos_mode_e;

  typedef enum logic [1:0] {
    TQOS_STD_525  = 2'h0,
    TQOS_STD_625  = 2'h1,
    TQOS_STD_USER = 2'h2
  } tqos_std_e;

  typedef enum logic [2:0] {
    TQOS_QUAL_EDGE    = 3'h0,
    TQOS_QUAL_PATTERN = 3'h1,
    TQOS_QUAL_STATE   = 3'h2,
    TQOS_QUAL_LOW     = 3'h3,
    TQOS_QUAL_HIGH    = 3'h4
  } tqos_qual_e;

  typedef enum logic [2:0] {
    TQOS_CMD_OCC_SLOPE  = 3'h0,
    TQOS_CMD_OCC_SOURCE = 3'h1,
    TQOS_CMD_PATH       = 3'h2,
    TQOS_CMD_POLARITY   = 3'h3,
    TQOS_CMD_QUALIFY    = 3'h4,
    TQOS_CMD_OCC_COUNT  = 3'h5
  } tqos_cmd_e;

  localparam int         TQOS_CNT_W     = 24;
  localparam logic [23:0] TQOS_OCC_MIN  = 24'h000001;
  localparam logic [23:0] TQOS_OCC_MAX  = 24'hF42400;
  localparam logic [23:0] TQOS_OCC_RST  = 24'h000001;
  localparam logic [1:0] TQOS_CHAN_RST  = 2'h0;
  localparam logic       TQOS_POS       = 1'b0;
  localparam logic       TQOS_NEG       = 1'b1;
  localparam int         TQOS_QTHR_W    = 12;
endpackage

/* File: design/tqos_edge_count.sv */
// counts selected-polarity transitions of the chosen channel up to a programmed number
`timescale 1ns/1ps
module tqos_edge_count
  import tqos_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  arm,
  input  wire logic [3:0]            chan_in,
  input  wire logic [1:0]            chan_sel,
  input  wire logic                  slope_neg,
  input  wire logic [TQOS_CNT_W-1:0] target,
  output logic                       done
);
  typedef struct packed {
    logic                  prev;
    logic [TQOS_CNT_W-1:0] cnt;
    logic                  done;
  } tqos_ec_s;

  tqos_ec_s st_q;
  tqos_ec_s st_d;
  logic     cur;
  logic     hit;

  always_comb begin
    st_d = st_q;
    cur  = chan_in[chan_sel];
    hit  = slope_neg ? (st_q.prev & ~cur) : (~st_q.prev & cur);
    st_d.prev = cur;
    if (!arm) begin
      st_d.cnt  = '0;
      st_d.done = 1'b0;
    end else if (hit && !st_q.done) begin
      st_d.cnt = st_q.cnt + TQOS_CNT_W'(1);
      if (st_q.cnt + TQOS_CNT_W'(1) >= target) begin
        st_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;
endmodule

/* File: design/tqos_setup.sv */
// trigger qualify, pattern path, polarity and occurrence setup with trigger qualification
`timescale 1ns/1ps
// Behaviour
// - counted-edge polarity accepted only in delayed or television mode
// - positive means rising transition, negative means falling transition
// - counted-edge query returns current choice, positive or negative
// - host picks which of four channels feeds the event counter
// - counted-channel selection accepted only in delayed mode
// - pattern-bit channel settable in pattern, clocked-pattern, or delayed on those
// - pattern-bit query returns channel selected for present mode
// - sync polarity accepted only in television mode with 525 or 625 standard
// - delayed mode qualifies on edge, pattern or clocked pattern; delayed only
// - chosen qualification applies its standalone mode's settings
// - high or low field qualification only in television user standard
// - high or low judged against channel's current trigger threshold
// - qualify query returns delayed qualifier or television high or low
// - delayed sweep held until programmed count of events, 1 to 16,000,000
// - clocked pattern: once pattern true, trigger on next clock transition
// - delayed: after qualification wait count, then enable trigger edge
module tqos_setup
  import tqos_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire tqos_mode_e            trig_mode,
  input  wire tqos_std_e             tv_standard,
  input  wire logic                  cmd_valid,
  input  wire tqos_cmd_e             cmd_code,
  input  wire logic [TQOS_CNT_W-1:0] cmd_value,
  input  wire logic [3:0]            input_channel_n,
  input  wire logic [1:0]            trig_source,
  input  wire logic                  trig_slope_neg,
  input  wire logic [2:0]            pattern_want,
  input  wire logic [2:0]            pattern_care,
  input  wire logic [TQOS_QTHR_W-1:0] chan_sample,
  input  wire logic [TQOS_QTHR_W-1:0] chan_threshold,
  output logic                       cmd_accept,
  output logic                       cmd_reject,
  output logic                       occ_slope_neg,
  output logic [1:0]                 occ_source,
  output logic [1:0]                 path_sel,
  output logic                       tv_polarity_neg,
  output tqos_qual_e                 qualify_sel,
  output logic [TQOS_CNT_W-1:0]      occ_count,
  output logic                       field_qual_ok,
  output logic                       trigger_out
);
  typedef struct packed {
    logic                  accept;
    logic                  reject;
    logic                  occ_neg;
    logic [1:0]            occ_src;
    logic [1:0]            path_dly;
    logic [1:0]            path_pat;
    logic [1:0]            path_st;
    logic                  tv_neg;
    tqos_qual_e            qual_dly;
    tqos_qual_e            qual_tv;
    logic [TQOS_CNT_W-1:0] occ_cnt;
    logic                  qualified;
    logic                  pat_true;
    logic                  prev_src;
    logic                  field_ok;
    logic                  trig;
    logic [1:0]            path_out;
    tqos_qual_e            qual_out;
  } tqos_st_s;

  tqos_st_s   st_q;
  tqos_st_s   st_d;
  logic       count_done;
  logic       ok;
  logic       pat_hit;
  logic       src_lvl;
  logic       src_edge;
  logic [1:0] chan_idx;
  logic       arm;

  assign arm = st_q.qualified && (trig_mode == TQOS_MODE_DELAY);

  tqos_edge_count u_count (
    .clock     (clock),
    .rst       (rst),
    .arm       (arm),
    .chan_in   (input_channel_n),
    .chan_sel  (st_q.occ_src),
    .slope_neg (st_q.occ_neg),
    .target    (st_q.occ_cnt),
    .done      (count_done)
  );

  always_comb begin
    st_d        = st_q;
    st_d.accept = 1'b0;
    st_d.reject = 1'b0;
    ok          = 1'b0;
    chan_idx    = cmd_value[1:0];
    if (cmd_valid) begin
      unique case (cmd_code)
        TQOS_CMD_OCC_SLOPE: begin
          ok = (trig_mode == TQOS_MODE_DELAY) || (trig_mode == TQOS_MODE_TV);
          if (ok) st_d.occ_neg = cmd_value[0];
        end
        TQOS_CMD_OCC_SOURCE: begin
          ok = (trig_mode == TQOS_MODE_DELAY);
          if (ok) st_d.occ_src = chan_idx;
        end
        TQOS_CMD_PATH: begin
          // path is kept per mode so the query reports the present mode's bit
          unique case (trig_mode)
            TQOS_MODE_PATTERN: begin
              ok = 1'b1;
              st_d.path_pat = chan_idx;
            end
            TQOS_MODE_STATE: begin
              ok = 1'b1;
              st_d.path_st = chan_idx;
            end
            TQOS_MODE_DELAY: begin
              ok = (st_q.qual_dly == TQOS_QUAL_PATTERN) ||
                   (st_q.qual_dly == TQOS_QUAL_STATE);
              if (ok) st_d.path_dly = chan_idx;
            end
            default: ok = 1'b0;
          endcase
        end
        TQOS_CMD_POLARITY: begin
          ok = (trig_mode == TQOS_MODE_TV) && (tv_standard != TQOS_STD_USER);
          if (ok) st_d.tv_neg = cmd_value[0];
        end
        TQOS_CMD_QUALIFY: begin
          if (trig_mode == TQOS_MODE_DELAY) begin
            ok = (cmd_value[2:0] <= 3'h2);
            if (ok) st_d.qual_dly = tqos_qual_e'(cmd_value[2:0]);
          end else if (trig_mode == TQOS_MODE_TV) begin
            ok = (tv_standard == TQOS_STD_USER) &&
                 (cmd_value[2:0] == 3'h3 || cmd_value[2:0] == 3'h4);
            if (ok) st_d.qual_tv = tqos_qual_e'(cmd_value[2:0]);
          end
        end
        TQOS_CMD_OCC_COUNT: begin
          ok = ((trig_mode == TQOS_MODE_DELAY) ||
                (trig_mode == TQOS_MODE_TV && tv_standard == TQOS_STD_USER)) &&
               (cmd_value >= TQOS_OCC_MIN) && (cmd_value <= TQOS_OCC_MAX);
          if (ok) st_d.occ_cnt = cmd_value;
        end
        default: ok = 1'b0;
      endcase
      st_d.accept = ok;
      st_d.reject = !ok;
    end

    // field level compare against the channel's present threshold
    st_d.field_ok = (st_q.qual_tv == TQOS_QUAL_HIGH) ? (chan_sample > chan_threshold)
                                                     : (chan_sample < chan_threshold);

    // qualification per chosen mode, using that mode's own settings
    pat_hit  = ((input_channel_n[2:0] ^ pattern_want) & pattern_care) == 3'h0;
    src_lvl  = input_channel_n[trig_source];
    src_edge = trig_slope_neg ? (st_q.prev_src & ~src_lvl) : (~st_q.prev_src & src_lvl);
    st_d.prev_src = src_lvl;
    st_d.pat_true = pat_hit;
    st_d.trig     = 1'b0;
    if (trig_mode == TQOS_MODE_STATE) begin
      st_d.trig = st_q.pat_true && src_edge;
    end
    if (trig_mode != TQOS_MODE_DELAY) begin
      st_d.qualified = 1'b0;
    end else if (!st_q.qualified) begin
      unique case (st_q.qual_dly)
        TQOS_QUAL_EDGE:    st_d.qualified = src_edge;
        TQOS_QUAL_PATTERN: st_d.qualified = pat_hit;
        TQOS_QUAL_STATE:   st_d.qualified = st_q.pat_true && src_edge;
        default:           st_d.qualified = 1'b0;
      endcase
    end else if (count_done && src_edge) begin
      // one trigger per qualification; rearms for the next sweep
      st_d.trig      = 1'b1;
      st_d.qualified = 1'b0;
    end

    // query copies are registered so every output leaves a flop;
    // they follow a mode change one cycle late
    if (trig_mode == TQOS_MODE_PATTERN) begin
      st_d.path_out = st_d.path_pat;
    end else if (trig_mode == TQOS_MODE_STATE) begin
      st_d.path_out = st_d.path_st;
    end else begin
      st_d.path_out = st_d.path_dly;
    end
    st_d.qual_out = (trig_mode == TQOS_MODE_TV) ? st_d.qual_tv : st_d.qual_dly;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q          <= '0;
      st_q.occ_cnt  <= TQOS_OCC_RST;
      st_q.qual_dly <= TQOS_QUAL_EDGE;
      st_q.qual_tv  <= TQOS_QUAL_LOW;
      st_q.occ_src  <= TQOS_CHAN_RST;
      st_q.occ_neg  <= TQOS_POS;
      st_q.tv_neg   <= TQOS_POS;
      st_q.path_dly <= TQOS_CHAN_RST;
      st_q.path_pat <= TQOS_CHAN_RST;
      st_q.path_st  <= TQOS_CHAN_RST;
      st_q.path_out <= TQOS_CHAN_RST;
      st_q.qual_out <= TQOS_QUAL_EDGE;
    end else begin
      st_q <= st_d;
    end
  end

  // query values, all straight from flops
  assign cmd_accept      = st_q.accept;
  assign cmd_reject      = st_q.reject;
  assign occ_slope_neg   = st_q.occ_neg;
  assign occ_source      = st_q.occ_src;
  assign path_sel        = st_q.path_out;
  assign tv_polarity_neg = st_q.tv_neg;
  assign qualify_sel     = st_q.qual_out;
  assign occ_count       = st_q.occ_cnt;
  assign field_qual_ok   = st_q.field_ok;
  assign trigger_out     = st_q.trig;
endmodule

/* File: verif/tqos_setup_properties.sv */
// assertions on command answers and stored settings of the setup block
`timescale 1ns/1ps
module tqos_setup_properties
  import tqos_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire tqos_mode_e            trig_mode,
  input wire tqos_std_e             tv_standard,
  input wire logic                  cmd_valid,
  input wire tqos_cmd_e             cmd_code,
  input wire logic [TQOS_CNT_W-1:0] cmd_value,
  input wire logic                  cmd_accept,
  input wire logic                  cmd_reject,
  input wire logic                  occ_slope_neg,
  input wire logic [1:0]            occ_source,
  input wire logic [TQOS_CNT_W-1:0] occ_count
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic dl     = trig_mode == TQOS_MODE_DELAY;
  wire logic tv     = trig_mode == TQOS_MODE_TV;
  wire logic pol_ok = tv && tv_standard != TQOS_STD_USER;
  wire logic bad_n  = cmd_value < TQOS_OCC_MIN || cmd_value > TQOS_OCC_MAX;
  wire logic fld    = cmd_value[2:0] == 3'h3 || cmd_value[2:0] == 3'h4;
  wire logic [1:0] src_v = cmd_value[1:0];
  one_answer_a: assert property (cmd_valid |=> cmd_accept != cmd_reject)
    else $error("command not answered once");
  idle_quiet_a: assert property (!cmd_valid |=> !cmd_accept && !cmd_reject)
    else $error("answer without command");
  slope_gate_a: assert property (cmd_valid && cmd_code == TQOS_CMD_OCC_SLOPE
    && !(dl || tv) |=> cmd_reject && $stable(occ_slope_neg))
    else $error("slope taken in wrong mode");
  slope_take_a: assert property (cmd_valid && cmd_code == TQOS_CMD_OCC_SLOPE
    && (dl || tv) |=> cmd_accept && occ_slope_neg == $past(cmd_value[0]))
    else $error("slope not stored");
  src_gate_a: assert property (cmd_valid && cmd_code == TQOS_CMD_OCC_SOURCE && !dl
    |=> cmd_reject && $stable(occ_source)) else $error("source taken outside delayed");
  src_take_a: assert property (cmd_valid && cmd_code == TQOS_CMD_OCC_SOURCE && dl
    |=> occ_source == $past(src_v)) else $error("source not stored");
  pol_gate_a: assert property (cmd_valid && cmd_code == TQOS_CMD_POLARITY
    |=> cmd_accept == $past(pol_ok)) else $error("polarity gating wrong");
  count_range_a: assert property (cmd_valid && cmd_code == TQOS_CMD_OCC_COUNT && bad_n
    |=> cmd_reject && $stable(occ_count)) else $error("count out of range taken");
  field_gate_a: assert property (cmd_valid && cmd_code == TQOS_CMD_QUALIFY && fld
    && !(tv && tv_standard == TQOS_STD_USER) |=> cmd_reject) else $error("field qualify taken");
  cover property (cmd_valid ##1 cmd_accept);
  cover property (cmd_valid ##1 cmd_reject);
  cover property (cmd_valid && cmd_code == TQOS_CMD_OCC_COUNT ##1 cmd_accept);
endmodule

bind tqos_setup tqos_setup_properties u_props (.clock, .rst, .trig_mode, .tv_standard,
  .cmd_valid, .cmd_code, .cmd_value, .cmd_accept, .cmd_reject, .occ_slope_neg,
  .occ_source, .occ_count);

/* File: verif/tqos_host.sv */
// host controller model issuing one setup command per cycle
`timescale 1ns/1ps
module tqos_host
  import tqos_pkg::*;
(
  input  wire logic                  clock,
  output logic                       cmd_valid,
  output tqos_cmd_e                  cmd_code,
  output logic [TQOS_CNT_W-1:0]      cmd_value
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = TQOS_CMD_OCC_SLOPE;
    cmd_value = '0;
  end
  // path is always sent ahead of any logic-level setting; this host issues none
  task automatic send(input tqos_cmd_e c, input logic [TQOS_CNT_W-1:0] v);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_value = v;
    @(posedge clock);
    #1;
  endtask
  // released value flips so a stale read cannot pass by luck
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_value = ~cmd_value;
    @(posedge clock);
    #1;
  endtask
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the setup block with a host model
`timescale 1ns/1ps
module testbench;
  import tqos_pkg::*;
  logic clock = 1'b0, rst = 1'b1, cmd_valid, cmd_accept, cmd_reject, occ_slope_neg;
  logic trig_slope_neg = 1'b0, tv_polarity_neg, field_qual_ok, trigger_out;
  tqos_mode_e trig_mode = TQOS_MODE_EDGE;
  tqos_std_e  tv_standard = TQOS_STD_525;
  tqos_cmd_e  cmd_code;
  tqos_qual_e qualify_sel;
  logic [23:0] cmd_value, occ_count, exp_cnt;
  logic [3:0] input_channel_n = 4'h0;
  logic [1:0] trig_source = 2'h0, occ_source, path_sel, exp_src, exp_path [0:4];
  logic [2:0] pattern_want = 3'h0, pattern_care = 3'h0, exp_dq, exp_tq;
  logic [11:0] chan_sample = 12'h000, chan_threshold = 12'h000;
  logic exp_slope, exp_pol;
  int fail_count = 0, n_checks = 0, cycles = 0;
  always #5 clock = ~clock;
  tqos_host u_tqos_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_value(cmd_value));
  tqos_setup u_tqos_setup (.clock(clock), .rst(rst), .trig_mode(trig_mode),
    .tv_standard(tv_standard), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_value(cmd_value), .input_channel_n(input_channel_n), .trig_source(trig_source),
    .trig_slope_neg(trig_slope_neg), .pattern_want(pattern_want),
    .pattern_care(pattern_care), .chan_sample(chan_sample), .chan_threshold(chan_threshold),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .occ_slope_neg(occ_slope_neg),
    .occ_source(occ_source), .path_sel(path_sel), .tv_polarity_neg(tv_polarity_neg),
    .qualify_sel(qualify_sel), .occ_count(occ_count), .field_qual_ok(field_qual_ok),
    .trigger_out(trigger_out));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(string n, logic [23:0] e, logic [23:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one channel change per clock, trigger pulse compared just after the edge
  task automatic step(logic [3:0] ch, bit e);
    input_channel_n = ch;
    @(posedge clock);
    #1;
    chk("trigger", e, trigger_out);
  endtask
  function automatic bit take(tqos_mode_e m, tqos_std_e s, tqos_cmd_e c, logic [23:0] v);
    bit dl = m == TQOS_MODE_DELAY;
    bit tvu = m == TQOS_MODE_TV && s == TQOS_STD_USER;
    case (c)
      TQOS_CMD_OCC_SLOPE:  return dl || m == TQOS_MODE_TV;
      TQOS_CMD_OCC_SOURCE: return dl;
      TQOS_CMD_PATH: return m inside {TQOS_MODE_PATTERN, TQOS_MODE_STATE} || dl && exp_dq != 0;
      TQOS_CMD_POLARITY:   return m == TQOS_MODE_TV && s != TQOS_STD_USER;
      TQOS_CMD_QUALIFY:    return v[2:0] < 3 ? dl : v[2:0] < 5 && tvu;
      TQOS_CMD_OCC_COUNT:  return (dl || tvu) && v >= TQOS_OCC_MIN && v <= TQOS_OCC_MAX;
      default:             return 1'b0;
    endcase
  endfunction
  // channel, source, slope and pattern inputs move at random; sample and threshold stay fixed
  task automatic cmd(tqos_mode_e m, tqos_std_e s, tqos_cmd_e c, logic [23:0] v);
    bit ok;
    ok = take(m, s, c, v);
    trig_mode = m;
    tv_standard = s;
    {input_channel_n, trig_source, trig_slope_neg, pattern_want, pattern_care} = 13'($urandom);
    u_tqos_host.send(c, v);
    chk("accept", ok, cmd_accept);
    chk("reject", !ok, cmd_reject);
    if (ok) begin
      case (c)
        TQOS_CMD_OCC_SLOPE:  exp_slope = v[0];
        TQOS_CMD_OCC_SOURCE: exp_src = v[1:0];
        TQOS_CMD_PATH:       exp_path[m] = v[1:0];
        TQOS_CMD_POLARITY:   exp_pol = v[0];
        TQOS_CMD_QUALIFY:    if (v[2:0] < 3) exp_dq = v[2:0]; else exp_tq = v[2:0];
        default:             exp_cnt = v;
      endcase
    end
    chk("slope", exp_slope, occ_slope_neg);
    chk("source", exp_src, occ_source);
    chk("polarity", exp_pol, tv_polarity_neg);
    chk("count", exp_cnt, occ_count);
    if (m inside {[1:3]}) chk("path", exp_path[m], path_sel);
    if (m == TQOS_MODE_DELAY) chk("dqual", exp_dq, qualify_sel);
    if (m == TQOS_MODE_TV) chk("tqual", exp_tq, qualify_sel);
  endtask
  initial begin
    tqos_cmd_e c;
    logic [23:0] v;
    void'($urandom(32'h357E04AA));
    {exp_slope, exp_pol, exp_src, exp_dq, exp_tq, exp_cnt} = {4'h0, 3'h0, 3'h3, 24'h000001};
    for (int i = 0; i < 5; i++) exp_path[i] = 2'h0;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_OCC_COUNT, 24'h000000);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_OCC_COUNT, TQOS_OCC_MIN);
    cmd(TQOS_MODE_TV, TQOS_STD_USER, TQOS_CMD_OCC_COUNT, TQOS_OCC_MAX);
    cmd(TQOS_MODE_TV, TQOS_STD_USER, TQOS_CMD_OCC_COUNT, 24'hF42401);
    cmd(TQOS_MODE_EDGE, TQOS_STD_525, TQOS_CMD_OCC_SLOPE, 24'h000001);
    cmd(TQOS_MODE_TV, TQOS_STD_625, TQOS_CMD_POLARITY, 24'h000001);
    cmd(TQOS_MODE_TV, TQOS_STD_USER, TQOS_CMD_POLARITY, 24'h000000);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_PATH, 24'h000003);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_QUALIFY, 24'h000002);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_PATH, 24'h000003);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_QUALIFY, 24'h000004);
    cmd(TQOS_MODE_TV, TQOS_STD_USER, TQOS_CMD_QUALIFY, 24'h000005);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, tqos_cmd_e'(3'h6), 24'h000001);
    $display("corner test done");
    for (int i = 0; i < 400; i++) begin
      c = tqos_cmd_e'($urandom % 6);
      v = c == TQOS_CMD_OCC_COUNT ? 24'($urandom % 24'hF42402) : 24'($urandom % 8);
      cmd(tqos_mode_e'($urandom % 5), tqos_std_e'($urandom % 3), c, v);
    end
    $display("random test done");
    // strict compare, so equal levels count as neither high nor low
    for (int q = 4; q >= 3; q--) begin
      cmd(TQOS_MODE_TV, TQOS_STD_USER, TQOS_CMD_QUALIFY, 24'(q));
      u_tqos_host.idle();
      for (int i = 0; i < 3; i++) begin
        chan_threshold = 12'h400;
        chan_sample = i == 0 ? 12'h800 : i == 1 ? 12'h300 : 12'h400;
        repeat (3) @(posedge clock);
        #1;
        chk("field", q == 4 ? i == 0 : i == 1, field_qual_ok);
      end
    end
    $display("field test done");
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_QUALIFY, 24'h000000);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_OCC_SOURCE, 24'h000001);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_OCC_SLOPE, 24'h000000);
    cmd(TQOS_MODE_DELAY, TQOS_STD_525, TQOS_CMD_OCC_COUNT, 24'h000002);
    u_tqos_host.idle();
    // clocked pattern on channels 2 and 3, clock edge on channel 1 rising
    {trig_source, trig_slope_neg, pattern_care, pattern_want} = {2'h0, 1'b0, 3'h6, 3'h6};
    trig_mode = TQOS_MODE_STATE;
    step(4'h0, 1'b0);
    step(4'h0, 1'b0);
    step(4'h1, 1'b0);
    step(4'h6, 1'b0);
    step(4'h7, 1'b1);
    step(4'h7, 1'b0);
    // delayed: qualify on channel 1 edge, count two rising edges of channel 2
    trig_mode = TQOS_MODE_EDGE;
    step(4'h0, 1'b0);
    step(4'h0, 1'b0);
    trig_mode = TQOS_MODE_DELAY;
    step(4'h0, 1'b0);
    step(4'h1, 1'b0);
    step(4'h2, 1'b0);
    step(4'h1, 1'b0);
    step(4'h3, 1'b0);
    step(4'h2, 1'b0);
    step(4'h3, 1'b1);
    step(4'h3, 1'b0);
    $display("trigger test done");
    print_verdict();
  end
endmodule
